// >>> rtl/sysctl_pkg.sv
// constants, register map and carrier types for the system control block
// assumes a 16-bit register port addressed by word and one 200 MHz clock
package sysctl_pkg;

    localparam int unsigned CLOCK_MHZ = 200;

    // register word addresses
    localparam logic [15:0] ADDR_HS_PRESCALE  = 16'h701a;
    localparam logic [15:0] ADDR_LS_PRESCALE  = 16'h701b;
    localparam logic [15:0] ADDR_PCLK_ENABLE  = 16'h701c;
    localparam logic [15:0] ADDR_SLEEP_CTRL0  = 16'h701e;
    localparam logic [15:0] ADDR_WAKE_SELECT  = 16'h701f;
    localparam logic [15:0] ADDR_PLL_RATIO    = 16'h7021;
    localparam logic [15:0] ADDR_SYS_STATUS   = 16'h7022;
    localparam logic [15:0] ADDR_WDOG_COUNTER = 16'h7023;
    localparam logic [15:0] ADDR_WDOG_KEY     = 16'h7025;
    localparam logic [15:0] ADDR_WDOG_CONTROL = 16'h7029;

    // reset values
    localparam logic [15:0] RST_HS_PRESCALE = 16'h0001;
    localparam logic [15:0] RST_LS_PRESCALE = 16'h0002;
    localparam logic [15:0] RST_PCLK_ENABLE = 16'h0000;
    localparam logic [7:0]  RST_SLEEP_QUAL  = 8'h00;
    localparam logic [14:0] RST_WAKE_SELECT = 15'h0000;
    localparam logic [3:0]  RST_PLL_RATIO   = 4'h0;

    // field positions
    localparam int unsigned LPM_LSB      = 0;  // sleep_ctrl0 [1:0]
    localparam int unsigned QUAL_LSB     = 2;  // sleep_ctrl0 [9:2]
    localparam int unsigned RATIO_MAX    = 10; // highest legal ratio code
    localparam int unsigned SCS_NMI_EN   = 0;
    localparam int unsigned SCS_LIMP     = 1;
    localparam int unsigned SCS_PLL_OFF  = 2;
    localparam int unsigned SCS_SETTLING = 3;
    localparam int unsigned WDC_FLAG     = 7;
    localparam int unsigned WDC_DISABLE  = 6;
    localparam int unsigned WDC_WAKE     = 5;

    // watchdog
    localparam logic [7:0]  WDOG_KEY_ARM     = 8'h55;
    localparam logic [7:0]  WDOG_KEY_SERVICE = 8'haa;
    localparam logic [7:0]  WDOG_MAX         = 8'hff;
    localparam int unsigned WDOG_RST_CYCLES  = 512;
    localparam int unsigned PLL_SETTLE_CYC   = 131072;

    typedef enum logic [3:0] {
        LP_RUN     = 4'b0001,
        LP_IDLE    = 4'b0010,
        LP_STANDBY = 4'b0100,
        LP_HALT    = 4'b1000
    } lp_state_t;

    // register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // standby wake sources, all active low, same order as wake-select bits
    typedef struct packed {
        logic       can_receive_pin;
        logic       serial_b_rx;
        logic       serial_a_rx;
        logic [5:0] compare_trip_inputs;
        logic [3:0] timer_trip_inputs;
        logic       ext_nonmaskable_in;
        logic       ext_irq_one;
    } wake_src_t;

endpackage

// >>> rtl/sys_clock_watchdog_lowpower.sv
// clock ratio control, limp fallback, watchdog and low-power sequencing
// assumes all inputs synchronous to clock; oscillator clock == clock
//
// Behaviour
// (R01) control registers take writes only while protected writes are enabled
// (R02) ratio register resets only on external reset, not debugger reset
// (R03) system clock is input times n over two, codes 0/1 give input/2
// (R04) lost input clock with PLL ratio set switches to limp clock
// (R05) watchdog counter holds while the input clock is missing
// (R06) software disables watchdog around ratio changes until PLL settles
// (R07) disable strap low at reset feeds input clock straight to the CPU
// (R08) after power-up with PLL allowed, bypass mode gives input/2
// (R09) watchdog at maximum drives reset low for 512 oscillator cycles
// (R10) key writes 0x55 then 0xaa clear the watchdog counter
// (R11) watchdog keeps running in standby and its wake ends standby
// (R12) in idle the watchdog wake reaches the CPU interrupt unit
// (R13) halt stops oscillator, PLL and watchdog
// (R14) mode field: 00 idle, 01 standby, 1x halt
// (R15) system clock output keeps running in idle
// (R16) wake source must stay low long enough, else stay in low power
// (R17) standby wake sources are qualified by programmed oscillator count
// (R18) standby wakes on selected sources; watchdog and debugger always
// (R19) halt ends only on external reset or enabled nonmaskable input; code also ends halt on debug_wake
// (R20) idle ends on enabled interrupt, nonmaskable input or watchdog wake
// (R21) low-power entry leaves pin states untouched
// (R22) boundary-scan port keeps working with the CPU clock stopped
// (R23) idle instruction enters the selected mode; qualified wake resumes
`timescale 1ns/1ps
`default_nettype none
module sys_clock_watchdog_lowpower
    import sysctl_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = PLL_SETTLE_CYC,
    parameter int unsigned WDOG_PRESCALE = 1
) (
    input  wire logic      clock,
    input  wire logic      resetn,
    input  wire logic      debug_reset,
    input  wire reg_req_t  req,
    output logic [15:0]    rdata,
    input  wire logic      protected_write_enable,
    input  wire logic      pll_disable_n,
    input  wire logic      ext_clock_present,
    input  wire logic      idle_instr,
    input  wire logic      irq_pending,
    input  wire logic      debug_wake,
    input  wire wake_src_t wake_src,
    output logic [3:0]     sysclk_mult,
    output logic           limp_clock_sel,
    output logic           pll_power_en,
    output logic           osc_clock_en,
    output logic           cpu_clock_en,
    output logic           system_clock_en,
    output logic           wdog_reset_n,
    output logic           wdog_wake_irq,
    output logic           lowpower_wake,
    output logic [15:0]    hs_prescale,
    output logic [15:0]    ls_prescale,
    output logic [15:0]    periph_clock_en
);

    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 32'h00ff_ffff) begin
        $error("SETTLE_CYCLES out of range");
    end
    if (WDOG_PRESCALE < 1 || WDOG_PRESCALE > 65535) begin
        $error("WDOG_PRESCALE out of range");
    end

    // multiplier n such that system clock = input * n / 2
    function automatic logic [3:0] ratio_mult(input logic [3:0] code,
                                              input logic       off);
        if (off)
            ratio_mult = 4'h2;
        else if (code < 4'h2)
            ratio_mult = 4'h1;
        else
            ratio_mult = code;
    endfunction

    function automatic logic hit(input logic [15:0] a);
        hit = req.addr == a;
    endfunction

    lp_state_t   state_q;
    logic [15:0] hs_q, ls_q, pclk_q;
    logic [9:0]  sleep_ctrl0_q;
    logic [14:0] wake_sel_q;
    logic [3:0]  ratio_q;
    logic        nmi_en_q;
    logic        pll_off_q, strap_taken_q;
    logic [23:0] settle_q;
    logic [7:0]  wcnt_q;
    logic [15:0] wpre_q;
    logic        key_armed_q;
    logic        wd_dis_q, wd_wake_mode_q, wd_flag_q;
    logic [9:0]  wrst_q;
    logic        wake_irq_q;
    logic [7:0]  qual_q;
    logic        lp_wake_q;
    logic [15:0] rdata_q;

    logic wr_ok, key_write, key_service, wd_run, wd_tick, wd_expire;
    logic limp, any_low, qualified;
    logic [14:0] src_low;

    assign wr_ok = req.wr && protected_write_enable; // R01
    assign key_write = wr_ok && req.addr == ADDR_WDOG_KEY;
    assign key_service = key_write && key_armed_q
                         && req.wdata[7:0] == WDOG_KEY_SERVICE; // R10

    // capture the disable strap at the first edge after reset release
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            strap_taken_q <= 1'b0;
            pll_off_q     <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            pll_off_q     <= !pll_disable_n; // R07
        end
    end

    // ratio register: external reset only, debugger reset leaves it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ratio_q <= RST_PLL_RATIO; // R02 R08
        end else if (wr_ok && hit(ADDR_PLL_RATIO)
                     && req.wdata[3:0] <= 4'(RATIO_MAX)) begin
            ratio_q <= req.wdata[3:0]; // R03
        end
    end

    // settling countdown after a ratio change, visible in status
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            settle_q <= '0;
        else if (wr_ok && hit(ADDR_PLL_RATIO))
            settle_q <= 24'(SETTLE_CYCLES); // R06
        else if (settle_q != '0)
            settle_q <= settle_q - 24'd1;
    end

    assign sysclk_mult = ratio_mult(ratio_q, pll_off_q); // R03 R07 R08
    // limp only possible with PLL in use and a non-zero ratio
    assign limp = !pll_off_q && ratio_q != 4'h0 && !ext_clock_present;
    assign limp_clock_sel = limp; // R04

    // plain control registers, loaded with their reset values by either reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hs_q          <= RST_HS_PRESCALE;
            ls_q          <= RST_LS_PRESCALE;
            pclk_q        <= RST_PCLK_ENABLE;
            sleep_ctrl0_q <= {RST_SLEEP_QUAL, 2'b00};
            wake_sel_q    <= RST_WAKE_SELECT;
            nmi_en_q      <= 1'b0;
            wd_dis_q      <= 1'b0;
            wd_wake_mode_q <= 1'b0;
        end else if (debug_reset) begin
            hs_q          <= RST_HS_PRESCALE;
            ls_q          <= RST_LS_PRESCALE;
            pclk_q        <= RST_PCLK_ENABLE;
            sleep_ctrl0_q <= {RST_SLEEP_QUAL, 2'b00};
            wake_sel_q    <= RST_WAKE_SELECT;
            nmi_en_q      <= 1'b0;
            wd_dis_q      <= 1'b0;
            wd_wake_mode_q <= 1'b0;
        end else if (wr_ok) begin // R01
            if (hit(ADDR_HS_PRESCALE))
                hs_q <= req.wdata;
            if (hit(ADDR_LS_PRESCALE))
                ls_q <= req.wdata;
            if (hit(ADDR_PCLK_ENABLE))
                pclk_q <= req.wdata;
            if (hit(ADDR_SLEEP_CTRL0))
                sleep_ctrl0_q <= req.wdata[9:0];
            if (hit(ADDR_WAKE_SELECT))
                wake_sel_q <= req.wdata[14:0];
            if (hit(ADDR_SYS_STATUS))
                nmi_en_q <= req.wdata[SCS_NMI_EN];
            if (hit(ADDR_WDOG_CONTROL)) begin
                wd_dis_q       <= req.wdata[WDC_DISABLE];
                wd_wake_mode_q <= req.wdata[WDC_WAKE];
            end
        end
    end

    assign hs_prescale     = hs_q; // R21
    assign ls_prescale     = ls_q;
    assign periph_clock_en = pclk_q;

    // watchdog: stops on missing input clock, in halt and while firing
    assign wd_run = !wd_dis_q && ext_clock_present // R05
                    && state_q != LP_HALT && wrst_q == '0; // R13 R11
    assign wd_tick = wd_run && wpre_q == 16'(WDOG_PRESCALE - 1);
    assign wd_expire = wd_tick && wcnt_q == WDOG_MAX - 8'd1;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            wpre_q <= '0;
        else if (!wd_run || wd_tick)
            wpre_q <= '0;
        else
            wpre_q <= wpre_q + 16'd1;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            key_armed_q <= 1'b0;
        else if (debug_reset)
            key_armed_q <= 1'b0;
        else if (key_write)
            key_armed_q <= req.wdata[7:0] == WDOG_KEY_ARM; // R10
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            wcnt_q <= '0;
        else if (debug_reset || key_service || wd_expire) // R10
            wcnt_q <= '0;
        else if (wd_tick)
            wcnt_q <= wcnt_q + 8'd1;
    end

    // reset pulse width counter; wake mode raises an interrupt instead
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            wrst_q <= '0;
        else if (wd_expire && !wd_wake_mode_q)
            wrst_q <= 10'(WDOG_RST_CYCLES); // R09
        else if (wrst_q != '0)
            wrst_q <= wrst_q - 10'd1;
    end
    assign wdog_reset_n = wrst_q == '0; // R09

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            wake_irq_q <= 1'b0;
        else
            wake_irq_q <= wd_expire && wd_wake_mode_q; // R11 R12
    end
    assign wdog_wake_irq = wake_irq_q; // R12

    // expiry flag: set beats a write-one clear in the same cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            wd_flag_q <= 1'b0;
        else if (wd_expire)
            wd_flag_q <= 1'b1;
        else if (wr_ok && hit(ADDR_WDOG_CONTROL) && req.wdata[WDC_FLAG])
            wd_flag_q <= 1'b0;
    end

    // wake qualification over consecutive low cycles
    assign src_low = state_q == LP_HALT
        ? {13'h0, !wake_src.ext_nonmaskable_in && nmi_en_q, 1'b0} // R19
        : ~wake_src & wake_sel_q; // R18
    assign any_low = src_low != '0;
    assign qualified = any_low
        && qual_q >= sleep_ctrl0_q[QUAL_LSB +: 8]; // R17

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            qual_q <= '0;
        else if (!any_low || state_q == LP_RUN || state_q == LP_IDLE)
            qual_q <= '0; // R16
        else if (qual_q != 8'hff)
            qual_q <= qual_q + 8'd1;
    end

    // mode sequencer; pins and boundary scan are outside its reach
    always_ff @(posedge clock or negedge resetn) begin // R21 R22
        if (!resetn) begin
            state_q   <= LP_RUN;
            lp_wake_q <= 1'b0;
        end else if (debug_reset) begin
            state_q   <= LP_RUN;
            lp_wake_q <= 1'b0;
        end else begin
            lp_wake_q <= 1'b0;
            unique case (state_q)
                LP_RUN: begin
                    if (idle_instr) begin // R23
                        unique casez (sleep_ctrl0_q[LPM_LSB +: 2]) // R14
                            2'b00:   state_q <= LP_IDLE;
                            2'b01:   state_q <= LP_STANDBY;
                            default: state_q <= LP_HALT;
                        endcase
                    end
                end
                LP_IDLE: begin
                    if (irq_pending || !wake_src.ext_nonmaskable_in
                        || wake_irq_q || debug_wake) begin // R20 R12
                        state_q   <= LP_RUN;
                        lp_wake_q <= 1'b1;
                    end
                end
                LP_STANDBY: begin
                    if (qualified || wake_irq_q || debug_wake) begin // R18
                        state_q   <= LP_RUN;
                        lp_wake_q <= 1'b1;
                    end
                end
                LP_HALT: begin
                    if (qualified || debug_wake) begin // R19
                        state_q   <= LP_RUN;
                        lp_wake_q <= 1'b1;
                    end
                end
            endcase
        end
    end
    assign lowpower_wake = lp_wake_q;

    // idle keeps system clock; standby keeps the oscillator and PLL power
    assign system_clock_en = state_q == LP_RUN || state_q == LP_IDLE; // R15
    assign cpu_clock_en    = state_q == LP_RUN || state_q == LP_IDLE; // R14
    assign osc_clock_en    = state_q != LP_HALT; // R13
    assign pll_power_en    = state_q != LP_HALT && !pll_off_q; // R13 R07

    // read port: data valid in the cycle after the strobe only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (req.rd) begin
            unique case (req.addr)
                ADDR_HS_PRESCALE:  rdata_q <= hs_q;
                ADDR_LS_PRESCALE:  rdata_q <= ls_q;
                ADDR_PCLK_ENABLE:  rdata_q <= pclk_q;
                ADDR_SLEEP_CTRL0:  rdata_q <= {6'h0, sleep_ctrl0_q};
                ADDR_WAKE_SELECT:  rdata_q <= {1'b0, wake_sel_q};
                ADDR_PLL_RATIO:    rdata_q <= {12'h0, ratio_q};
                ADDR_SYS_STATUS:   rdata_q <= {12'h0, settle_q != '0,
                                               pll_off_q, limp, nmi_en_q};
                ADDR_WDOG_COUNTER: rdata_q <= {8'h0, wcnt_q};
                ADDR_WDOG_CONTROL: rdata_q <= {8'h0, wd_flag_q, wd_dis_q,
                                               wd_wake_mode_q, 5'h0};
                default:           rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end
    assign rdata = rdata_q;

endmodule
`default_nettype wire

// >>> sim/sysctl_asserts.sv
// port assertions for the system control block
// assumes one clock domain; bound to the block's top module
`timescale 1ns/1ps
`default_nettype none
module sysctl_asserts
    import sysctl_pkg::*;
(
    input wire logic       clock,
    input wire logic       resetn,
    input wire reg_req_t   req,
    input wire logic       protected_write_enable,
    input wire logic       pll_disable_n,
    input wire logic       ext_clock_present,
    input wire logic [3:0] sysclk_mult,
    input wire logic       limp_clock_sel,
    input wire logic       pll_power_en,
    input wire logic       osc_clock_en,
    input wire logic       cpu_clock_en,
    input wire logic       system_clock_en,
    input wire logic       wdog_reset_n,
    input wire logic       wdog_wake_irq,
    input wire logic       lowpower_wake
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    logic [9:0] low_q;
    logic       rwr;
    assign rwr = req.wr && req.addr == ADDR_PLL_RATIO;
    // counts low cycles of the watchdog reset pulse
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            low_q <= 10'h000;
        end else begin
            low_q <= wdog_reset_n ? 10'h000 : low_q + 10'h001;
        end
    end
    sequence s_awake;
        cpu_clock_en && osc_clock_en && pll_power_en;
    endsequence
    wd_len_a: assert property ($rose(wdog_reset_n) |-> low_q == 10'h200)
        else $error("watchdog pulse too short");
    wd_max_a: assert property (low_q <= 10'h200)
        else $error("watchdog pulse too long");
    wake_state_a: assert property (lowpower_wake |-> s_awake ##1 !lowpower_wake)
        else $error("wake pulse or clocks wrong");
    ratio_set_a: assert property (rwr && protected_write_enable && pll_disable_n
        && req.wdata[3:0] <= 4'ha |=> sysclk_mult ==
        ($past(req.wdata[3:0]) < 4'h2 ? 4'h1 : $past(req.wdata[3:0])))
        else $error("ratio not applied");
    ratio_rsv_a: assert property (rwr && req.wdata[3:0] > 4'ha |=> $stable(sysclk_mult))
        else $error("reserved ratio applied");
    ratio_lock_a: assert property (rwr && !protected_write_enable |=> $stable(sysclk_mult))
        else $error("locked ratio write applied");
    limp_src_a: assert property (limp_clock_sel |-> !ext_clock_present)
        else $error("limp clock with input present");
    clk_pair_a: assert property (system_clock_en == cpu_clock_en)
        else $error("system and cpu clock enables differ");
    halt_off_a: assert property (!osc_clock_en |-> !pll_power_en && !cpu_clock_en)
        else $error("clocks left on in halt");
    wd_hold_a: assert property (!ext_clock_present && !$past(ext_clock_present, 2)
        |-> !$fell(wdog_reset_n) && !wdog_wake_irq)
        else $error("watchdog fired without input clock");
endmodule
bind sys_clock_watchdog_lowpower sysctl_asserts u_sysctl_asserts (
    .clock, .resetn, .req, .protected_write_enable, .pll_disable_n,
    .ext_clock_present, .sysclk_mult, .limp_clock_sel, .pll_power_en,
    .osc_clock_en, .cpu_clock_en, .system_clock_en, .wdog_reset_n,
    .wdog_wake_irq, .lowpower_wake);
`default_nettype wire

// >>> sim/osc_cpu_model.sv
// stand-in for the oscillator and the cpu core at the far side
// assumes the bench asks for clock loss and idle by level inputs
`timescale 1ns/1ps
`default_nettype none
module osc_cpu_model (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic lose_clk,
    input  wire logic idle_req,
    output logic      ext_clock_present,
    output logic      idle_instr
);
    logic req_q;
    // loss is seen a cycle late, as a real detector would report it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ext_clock_present <= 1'b1;
        end else begin
            ext_clock_present <= !lose_clk;
        end
    end
    // a held request executes the idle instruction only once
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            req_q <= 1'b0;
            idle_instr <= 1'b0;
        end else begin
            req_q <= idle_req;
            idle_instr <= idle_req && !req_q;
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb_sys_clock_watchdog_lowpower.sv
// bench for the system control block: register tasks and scenarios
// assumes osc_cpu_model for clock loss and the idle instruction
`timescale 1ns/1ps
`default_nettype none
module tb_sys_clock_watchdog_lowpower
    import sysctl_pkg::*;
();
    logic        clock, resetn, debug_reset, protected_write_enable;
    logic        pll_disable_n, lose_clk, idle_req, irq_pending, got;
    logic        debug_wake, limp_clock_sel, pll_power_en, osc_clock_en;
    logic        cpu_clock_en, system_clock_en, wdog_reset_n, idle_instr;
    logic        wdog_wake_irq, lowpower_wake, ext_clock_present;
    logic [3:0]  sysclk_mult;
    logic [15:0] rdata, hs_prescale, ls_prescale, periph_clock_en, v, w;
    reg_req_t    req;
    wake_src_t   wake_src;
    int          failures, checked, n;
    logic [15:0] ra [5] = '{ADDR_HS_PRESCALE, ADDR_LS_PRESCALE,
                            ADDR_PCLK_ENABLE, ADDR_PLL_RATIO, 16'h7024};
    logic [15:0] rv [5] = '{RST_HS_PRESCALE, RST_LS_PRESCALE,
                            RST_PCLK_ENABLE, 16'h0000, 16'h0000};
    sys_clock_watchdog_lowpower #(.SETTLE_CYCLES(16))
    u_sys_clock_watchdog_lowpower (
        .clock, .resetn, .debug_reset, .req, .rdata, .protected_write_enable,
        .pll_disable_n, .ext_clock_present, .idle_instr, .irq_pending,
        .debug_wake, .wake_src, .sysclk_mult, .limp_clock_sel, .pll_power_en,
        .osc_clock_en, .cpu_clock_en, .system_clock_en, .wdog_reset_n,
        .wdog_wake_irq, .lowpower_wake, .hs_prescale, .ls_prescale,
        .periph_clock_en);
    osc_cpu_model u_osc_cpu_model (.clock, .resetn, .lose_clk, .idle_req,
        .ext_clock_present, .idle_instr);
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req <= '0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req <= '0;
        #1;
        d = rdata;
    endtask
    task automatic chk(input string s, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wait_wake(input int lim);
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++) begin
            cyc(1);
            got = (lowpower_wake === 1'b1);
        end
    endtask
    task automatic sleep(input logic [15:0] ctl);
        wr(ADDR_SLEEP_CTRL0, ctl);
        idle_req <= 1'b1;
        cyc(1);
        idle_req <= 1'b0;
        cyc(3);
    endtask
    task automatic stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #100000;
        failures++;
        stop_test();
    end
    initial begin
        resetn = 1'b0;
        debug_reset = 1'b0;
        protected_write_enable = 1'b0;
        pll_disable_n = 1'b1;
        lose_clk = 1'b0;
        idle_req = 1'b0;
        irq_pending = 1'b0;
        debug_wake = 1'b0;
        req = '0;
        wake_src = '1;
        failures = 0;
        checked = 0;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        cyc(2);
        chk("bypass mult", 16'(sysclk_mult), 16'h0001);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], v);
            chk("reset value", v, rv[i]);
        end
        wr(ADDR_PLL_RATIO, 16'h0004);
        rd(ADDR_PLL_RATIO, v);
        chk("locked write", v, 16'h0000);
        protected_write_enable <= 1'b1;
        wr(ADDR_WDOG_CONTROL, 16'h0040);
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_PLL_RATIO, 16'(c));
            n = (c > RATIO_MAX) ? RATIO_MAX : c;
            rd(ADDR_PLL_RATIO, v);
            chk("ratio reg", v, 16'(n));
            chk("mult", 16'(sysclk_mult), 16'(n < 2 ? 1 : n));
        end
        wr(ADDR_HS_PRESCALE, 16'h0007);
        debug_reset <= 1'b1;
        cyc(1);
        debug_reset <= 1'b0;
        rd(ADDR_PLL_RATIO, v);
        chk("ratio kept", v, 16'h000a);
        chk("hs reset", hs_prescale, RST_HS_PRESCALE);
        chk("ls reset", ls_prescale, RST_LS_PRESCALE);
        $display("ratio tests done");
        wr(ADDR_WDOG_CONTROL, 16'h0000);
        lose_clk <= 1'b1;
        cyc(3);
        chk("limp", 16'(limp_clock_sel), 16'h0001);
        rd(ADDR_WDOG_COUNTER, v);
        cyc(40);
        rd(ADDR_WDOG_COUNTER, w);
        chk("frozen count", w, v);
        lose_clk <= 1'b0;
        wr(ADDR_WDOG_KEY, 16'h0055);
        wr(ADDR_WDOG_KEY, 16'h00aa);
        rd(ADDR_WDOG_COUNTER, v);
        chk("key clear", 16'(v < 16'h0003), 16'h0001);
        cyc(100);
        wr(ADDR_WDOG_KEY, 16'h0055);
        wr(ADDR_WDOG_KEY, 16'h0012);
        wr(ADDR_WDOG_KEY, 16'h00aa);
        rd(ADDR_WDOG_COUNTER, v);
        chk("bad key order", 16'(v >= 16'h0064), 16'h0001);
        wr(ADDR_WDOG_KEY, 16'h0055);
        wr(ADDR_WDOG_KEY, 16'h00aa);
        for (n = 0; wdog_reset_n === 1'b1 && n < 400; n++) cyc(1);
        chk("expiry time", 16'(n >= 255 && n <= 257), 16'h0001);
        for (n = 0; wdog_reset_n === 1'b0 && n < 600; n++) cyc(1);
        chk("pulse length", 16'(n), 16'(WDOG_RST_CYCLES));
        wr(ADDR_WDOG_CONTROL, 16'h0020);
        wr(ADDR_WAKE_SELECT, 16'h0000);
        wr(ADDR_WDOG_KEY, 16'h0055);
        wr(ADDR_WDOG_KEY, 16'h00aa);
        sleep(16'h000d);
        wait_wake(300);
        chk("wdog wake", 16'(got), 16'h0001);
        wr(ADDR_WDOG_CONTROL, 16'h0040);
        $display("watchdog tests done");
        sleep(16'h0000);
        chk("idle clocks", 16'(system_clock_en), 16'h0001);
        wait_wake(10);
        chk("idle stays", 16'(got), 16'h0000);
        irq_pending <= 1'b1;
        wait_wake(6);
        chk("idle exit", 16'(got), 16'h0001);
        irq_pending <= 1'b0;
        // one pass per wake source; neighbour stands in as unselected
        for (int i = 0; i < 15; i++) begin
            wr(ADDR_WAKE_SELECT, 16'h0001 << i);
            sleep(16'h000d);
            chk("standby", 16'({osc_clock_en, cpu_clock_en}), 16'h0002);
            wake_src <= wake_src_t'(~(15'h0001 << ((i + 1) % 15)));
            wait_wake(10);
            chk("unselected", 16'(got), 16'h0000);
            wake_src <= wake_src_t'(~(15'h0001 << i));
            cyc(3);
            wake_src <= '1;
            wait_wake(8);
            chk("short low", 16'(got), 16'h0000);
            wake_src <= wake_src_t'(~(15'h0001 << i));
            wait_wake(12);
            chk("source wake", 16'(got), 16'h0001);
            wake_src <= '1;
        end
        wr(ADDR_SYS_STATUS, 16'h0001);
        wr(ADDR_WAKE_SELECT, 16'h0001);
        sleep(16'h000e);
        debug_wake <= 1'b1;
        wait_wake(8);
        chk("debug wake", 16'(got), 16'h0001);
        debug_wake <= 1'b0;
        wr(ADDR_PCLK_ENABLE, 16'h00c3);
        sleep(16'h000f);
        chk("halt", 16'({pll_power_en, osc_clock_en}), 16'h0000);
        wake_src.ext_irq_one <= 1'b0;
        wait_wake(12);
        chk("halt ignores", 16'(got), 16'h0000);
        wake_src <= wake_src_t'(~15'h0002);
        wait_wake(12);
        chk("halt nmi exit", 16'(got), 16'h0001);
        wake_src <= '1;
        chk("pins kept", hs_prescale, RST_HS_PRESCALE);
        chk("pclk kept", periph_clock_en, 16'h00c3);
        $display("low power tests done");
        resetn <= 1'b0;
        pll_disable_n <= 1'b0;
        cyc(2);
        resetn <= 1'b1;
        cyc(2);
        wr(ADDR_PLL_RATIO, 16'h0005);
        chk("pll off mult", 16'(sysclk_mult), 16'h0002);
        $display("strap test done");
        stop_test();
    end
endmodule
`default_nettype wire
